// ---- frs_map.svh ----
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FRS_CLK_HZ          10000000
`define FRS_TICK_MS         100
`define FRS_TICK_CYC        (`FRS_CLK_HZ / 1000 * `FRS_TICK_MS)
`define FRS_EARTH_MS        20
`define FRS_EARTH_CYC       (`FRS_CLK_HZ / 1000 * `FRS_EARTH_MS)
`define FRS_ILF_MS          1000
`define FRS_ILF_TICKS       (`FRS_ILF_MS / `FRS_TICK_MS)
`define FRS_WAIT_MIN_TICKS  12'h001
`define FRS_WAIT_MAX_TICKS  12'hE10
`define FRS_SUCCESS_SHIFT   2
`define FRS_LIMIT_OFFSET    7'h64
`define FRS_SUCC_MAX        16'hFFFF

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FRS_A_CTRL          8'h00
`define FRS_A_LIMIT         8'h04
`define FRS_A_WAIT          8'h08
`define FRS_A_SUCC          8'h0C
`define FRS_A_STAT          8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FRS_CTRL_SEL_LSB    0
`define FRS_CTRL_SEL_MSB    2
`define FRS_CTRL_OPL        4
`define FRS_CTRL_IPL        5
`define FRS_CTRL_EFC        6
`define FRS_CTRL_POL        7
`define FRS_STAT_CLR        0
`define FRS_STAT_PE         3
`define FRS_STAT_EXC        4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FRS_CTRL_RST        8'h70
`define FRS_LIMIT_RST       7'h00
`define FRS_WAIT_RST        12'h00A

// ----------------------------------------
// Retry masks per selection
// ----------------------------------------
`define FRS_MASK_SEL0       22'h0FFFFF
`define FRS_MASK_SEL1       22'h000007
`define FRS_MASK_SEL2       22'h000038
`define FRS_MASK_SEL3       22'h00003F
`define FRS_MASK_SEL4       22'h0FF73F
`define FRS_MASK_SEL5       22'h000005

`endif

// ---- frs_pkg.sv ----
`default_nettype none

package frs_pkg;

	// Supervisor states
	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_WAIT,
		ST_PROBE,
		ST_LOCKED
	} frs_state_t;

	// Fault codes, index into the fault vector
	typedef enum logic [4:0] {
		overcurrent_accel_fault,
		overcurrent_const_fault,
		overcurrent_decel_fault,
		overvoltage_accel_fault,
		overvoltage_const_fault,
		overvoltage_decel_fault,
		motor_thermal_fault,
		drive_thermal_fault,
		brake_transistor_fault,
		earth_fault_overcurrent,
		comm_link_fault,
		external_thermal_fault,
		stall_stop_fault,
		option_fault,
		param_storage_fault,
		internal_fault_a,
		internal_fault_b,
		internal_fault_c,
		internal_fault_d,
		input_phase_loss_fault,
		output_phase_loss_fault,
		retry_excess_fault
	} frs_fault_t;

	localparam int NFAULT = 22;
	localparam int NEXT   = 20;

endpackage

`default_nettype wire

// ---- frs_tick_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// Tick strobe between divider and supervisor
interface frs_tick_if;
	logic tick;
	logic clr;
	modport src (input clr, output tick);
	modport snk (input tick, output clr);
endinterface

`default_nettype wire

// ---- frs_tick_gen.sv ----
`timescale 1ns/100ps
`default_nettype none

module frs_tick_gen #(
	parameter int unsigned CYCLES = 1000000
) (
	input  wire logic  clk,
	input  wire logic  resetn,
	frs_tick_if.src    bus
);
	localparam int W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;
	logic         tick_q;

	// Divider, restarted by clr so a wait starts on a full tick
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else if (bus.clr) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
			tick_q <= (cnt_q == LAST);
		end
	end

	assign bus.tick = tick_q;
endmodule

`default_nettype wire

// ---- frs_supervisor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "frs_map.svh"

module frs_supervisor #(
	parameter int unsigned TICK_CYCLES  = `FRS_TICK_CYC,
	parameter int unsigned EARTH_CYCLES = `FRS_EARTH_CYC
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output var  logic [31:0]   prdata,
	output var  logic          pready,
	output var  logic          pslverr,
	input  wire logic [19:0]   extFault,
	input  wire logic          startCmd,
	input  wire logic          running,
	input  wire logic          dcBraking,
	input  wire logic          outFreqAbove1Hz,
	input  wire logic          outPhaseLost,
	input  wire logic          inPhaseLost,
	input  wire logic          regenerating,
	input  wire logic          earthFaultSense,
	output var  logic          tripOut,
	output var  logic          faultOut,
	output var  logic          retry_active_out,
	output var  logic          faultResetRestart,
	output var  logic          outputGate,
	output var  logic          retryExcess,
	output var  frs_pkg::frs_fault_t faultRecord
);
	import frs_pkg::*;

	localparam int EW = $clog2(EARTH_CYCLES);
	localparam logic [EW-1:0] EARTH_LAST = EW'(EARTH_CYCLES - 1);
	localparam logic [3:0] ILF_TICKS = 4'(`FRS_ILF_TICKS);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Retry mask for a fault selection
	function automatic logic retryable(input logic [2:0] sel, input frs_fault_t code);
		logic [NFAULT-1:0] mask;
		case (sel)
			3'h0: mask = `FRS_MASK_SEL0;
			3'h1: mask = `FRS_MASK_SEL1;
			3'h2: mask = `FRS_MASK_SEL2;
			3'h3: mask = `FRS_MASK_SEL3;
			3'h4: mask = `FRS_MASK_SEL4;
			3'h5: mask = `FRS_MASK_SEL5;
			default: mask = '0;
		endcase
		return mask[code];
	endfunction

	// Lowest numbered active fault
	function automatic frs_fault_t firstFault(input logic [NFAULT-1:0] v);
		frs_fault_t f;
		f = overcurrent_accel_fault;
		for (int i = NFAULT - 1; i >= 0; i--) begin
			if (v[i]) begin
				f = frs_fault_t'(5'(i));
			end
		end
		return f;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	frs_tick_if tickBus ();

	logic [7:0]        ctrl_q;
	logic [6:0]        limit_q;
	logic [11:0]       wait_q;
	logic [15:0]       succ_q;
	logic              ready_q;
	logic              slverr_q;
	logic [31:0]       rdata_q;
	frs_state_t        state_q, state_d;
	logic [15:0]       tmr_q;
	logic [6:0]        retries_q;
	logic              excess_q, excess_d;
	frs_fault_t        record_q;
	logic              peLatched_q;
	logic              powerUpWin_q;
	logic              startPrev_q;
	logic              checking_q;
	logic [EW-1:0]     chkCnt_q;
	logic [3:0]        ilfCnt_q;
	logic              trip_q, fault_q, active_q, restart_q, gate_q;
	logic [NFAULT-1:0] faultVec;
	logic [31:0]       rdMux;
	logic              mapped, access, wrEn;
	logic              tick, tripEvent, retryOk, waitDone, succDone, clrLock;
	logic              lfDetect, ilfDetect, gfDetect, startEvt, inRetry;
	logic [6:0]        effLimit;
	logic [11:0]       effWait;
	frs_fault_t        code;

	// ----------------------------------------
	// Tick divider
	// ----------------------------------------
	frs_tick_gen #(.CYCLES(TICK_CYCLES)) uTick (
		.clk    (clk),
		.resetn (resetn),
		.bus    (tickBus.src)
	);

	// Restart the tick on wait entry so the wait is whole ticks
	assign tickBus.clr = (state_d == ST_WAIT) && (state_q != ST_WAIT);
	assign tick        = tickBus.tick;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign access = psel && penable;
	assign wrEn   = access && ready_q && pwrite;

	// Address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rdMux  = '0;
		case (paddr)
			`FRS_A_CTRL:  rdMux[7:0]   = ctrl_q;
			`FRS_A_LIMIT: rdMux[6:0]   = limit_q;
			`FRS_A_WAIT:  rdMux[11:0]  = wait_q;
			`FRS_A_SUCC:  rdMux[15:0]  = succ_q;
			`FRS_A_STAT: begin
				rdMux[1:0]         = state_q;
				rdMux[`FRS_STAT_PE]  = peLatched_q;
				rdMux[`FRS_STAT_EXC] = excess_q;
				rdMux[12:8]        = record_q;
				rdMux[22:16]       = retries_q;
			end
			default: mapped = 1'b0;
		endcase
	end

	// One wait state: answer in the second access cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ready_q  <= 1'b0;
			slverr_q <= 1'b0;
			rdata_q  <= '0;
		end else begin
			ready_q  <= access && !ready_q;
			slverr_q <= access && !ready_q && !mapped;
			if (access && !ready_q) begin
				rdata_q <= pwrite ? 32'h0000_0000 : rdMux;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q  <= `FRS_CTRL_RST;
			limit_q <= `FRS_LIMIT_RST;
			wait_q  <= `FRS_WAIT_RST;
		end else if (wrEn) begin
			case (paddr)
				`FRS_A_CTRL:  ctrl_q  <= pwdata[7:0];
				`FRS_A_LIMIT: limit_q <= pwdata[6:0];
				`FRS_A_WAIT:  wait_q  <= (pwdata[11:0] > `FRS_WAIT_MAX_TICKS) ?
					`FRS_WAIT_MAX_TICKS : pwdata[11:0];
				default: ;
			endcase
		end
	end

	assign clrLock = wrEn && (paddr == `FRS_A_STAT) && pwdata[`FRS_STAT_CLR];

	// ----------------------------------------
	// Protection detectors
	// ----------------------------------------

	// Output phase loss while running, not braking, above 1Hz
	assign lfDetect = ctrl_q[`FRS_CTRL_OPL] && running && !dcBraking
		&& outFreqAbove1Hz && outPhaseLost;

	// Input phase loss must persist a full second of ticks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ilfCnt_q <= '0;
		end else if (!ctrl_q[`FRS_CTRL_IPL] || !inPhaseLost || regenerating) begin
			ilfCnt_q <= '0;
		end else if (tick && ilfCnt_q != ILF_TICKS) begin
			ilfCnt_q <= ilfCnt_q + 1'b1;
		end
	end
	assign ilfDetect = (ilfCnt_q == ILF_TICKS);

	// Start event: rising start command or a retry restart
	assign startEvt = (startCmd && !startPrev_q) || restart_q;

	// Earth check window right after each start
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			startPrev_q <= 1'b0;
			checking_q  <= 1'b0;
			chkCnt_q    <= '0;
		end else begin
			startPrev_q <= startCmd;
			if (startEvt && ctrl_q[`FRS_CTRL_EFC]) begin
				checking_q <= 1'b1;
				chkCnt_q   <= '0;
			end else if (checking_q) begin
				chkCnt_q   <= chkCnt_q + 1'b1;
				checking_q <= (chkCnt_q != EARTH_LAST);
			end
		end
	end

	// Sense counts only inside the check window
	assign gfDetect = checking_q && ctrl_q[`FRS_CTRL_EFC] && earthFaultSense;

	// Collect every trip source
	always_comb begin
		faultVec = {2'b00, extFault};
		faultVec[earth_fault_overcurrent] = extFault[earth_fault_overcurrent] || gfDetect;
		faultVec[input_phase_loss_fault]  = extFault[input_phase_loss_fault] || ilfDetect;
		faultVec[output_phase_loss_fault] = lfDetect;
	end

	// Parameter storage fault seen in the first tick after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			powerUpWin_q <= 1'b1;
			peLatched_q  <= 1'b0;
		end else begin
			if (tick) begin
				powerUpWin_q <= 1'b0;
			end
			if (powerUpWin_q && extFault[param_storage_fault]) begin
				peLatched_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Retry sequencer
	// ----------------------------------------
	assign effLimit  = (limit_q > `FRS_LIMIT_OFFSET) ? limit_q - `FRS_LIMIT_OFFSET
		: limit_q;
	assign effWait   = (wait_q == 12'h000) ? `FRS_WAIT_MIN_TICKS : wait_q;
	assign code      = firstFault(faultVec);
	assign tripEvent = ((state_q == ST_NORMAL) || (state_q == ST_PROBE)) && (|faultVec);
	assign retryOk   = retryable(ctrl_q[`FRS_CTRL_SEL_MSB:`FRS_CTRL_SEL_LSB], code)
		&& (effLimit != 7'h00) && !peLatched_q;
	assign waitDone  = (state_q == ST_WAIT) && (tmr_q >= {4'h0, effWait});
	assign succDone  = (state_q == ST_PROBE)
		&& (tmr_q > {2'b00, effWait, `FRS_SUCCESS_SHIFT'(0)});
	assign inRetry   = (state_d == ST_WAIT) || (state_d == ST_PROBE);

	// Next state and excess flag
	always_comb begin
		state_d  = state_q;
		excess_d = excess_q;
		case (state_q)
			ST_NORMAL, ST_PROBE: begin
				if (tripEvent) begin
					if (!retryOk) begin
						state_d = ST_LOCKED;
					end else if (retries_q >= effLimit) begin
						state_d  = ST_LOCKED;
						excess_d = 1'b1;
					end else begin
						state_d = ST_WAIT;
					end
				end else if (succDone) begin
					state_d = ST_NORMAL;
				end
			end
			ST_WAIT: begin
				if (waitDone) begin
					state_d = ST_PROBE;
				end
			end
			ST_LOCKED: begin
				if (clrLock) begin
					state_d  = ST_NORMAL;
					excess_d = 1'b0;
				end
			end
			default: state_d = ST_NORMAL;
		endcase
	end

	// State, excess flag and tick timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q  <= ST_NORMAL;
			excess_q <= 1'b0;
			tmr_q    <= '0;
		end else begin
			state_q  <= state_d;
			excess_q <= excess_d;
			if (state_d != state_q) begin
				tmr_q <= '0;
			end else if (tick && tmr_q != 16'hFFFF) begin
				tmr_q <= tmr_q + 1'b1;
			end
		end
	end

	// Consecutive retry count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			retries_q <= '0;
		end else if (succDone || (state_q == ST_LOCKED && clrLock)) begin
			retries_q <= '0;
		end else if (waitDone) begin
			retries_q <= retries_q + 1'b1;
		end
	end

	// First fault of a sequence is kept
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			record_q <= overcurrent_accel_fault;
		end else if (tripEvent && state_q == ST_NORMAL) begin
			record_q <= code;
		end
	end

	// Successful retry counter, a clear in the same cycle as a success loads 1
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			succ_q <= '0;
		end else if (succDone) begin
			if (wrEn && paddr == `FRS_A_SUCC && pwdata[15:0] == 16'h0000) begin
				succ_q <= 16'h0001;
			end else if (succ_q != `FRS_SUCC_MAX) begin
				succ_q <= succ_q + 1'b1;
			end
		end else if (wrEn && paddr == `FRS_A_SUCC && pwdata[15:0] == 16'h0000) begin
			succ_q <= '0;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------

	// Drive-side outputs; restart pulse clears only the trip, not
	// the thermal or brake duty accumulators held downstream
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trip_q    <= 1'b0;
			fault_q   <= 1'b0;
			active_q  <= 1'b0;
			restart_q <= 1'b0;
			gate_q    <= 1'b0;
		end else begin
			trip_q    <= (state_d == ST_WAIT) || (state_d == ST_LOCKED);
			fault_q   <= (state_d == ST_LOCKED)
				|| (inRetry && limit_q > `FRS_LIMIT_OFFSET);
			active_q  <= inRetry ^ ctrl_q[`FRS_CTRL_POL];
			restart_q <= waitDone;
			gate_q    <= startCmd && !checking_q && !startEvt
				&& ((state_d == ST_NORMAL) || (state_d == ST_PROBE));
		end
	end

	assign prdata            = rdata_q;
	assign pready            = ready_q;
	assign pslverr           = slverr_q;
	assign tripOut           = trip_q;
	assign faultOut          = fault_q;
	assign retry_active_out  = active_q;
	assign faultResetRestart = restart_q;
	assign outputGate        = gate_q;
	assign retryExcess       = excess_q;
	assign faultRecord       = record_q;
endmodule

`default_nettype wire

// ---- frs_supervisor_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "frs_map.svh"

module frs_supervisor_asserts #(
	parameter int unsigned TICK_CYCLES  = 1000000,
	parameter int unsigned EARTH_CYCLES = 200000
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        startCmd,
	input wire logic        tripOut,
	input wire logic        faultOut,
	input wire logic        retry_active_out,
	input wire logic        faultResetRestart,
	input wire logic        outputGate,
	input wire logic        retryExcess
);
	logic efc_q;
	logic pol_q;

	// Shadow of the earth check and polarity control bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			efc_q <= 1'b1;
			pol_q <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == `FRS_A_CTRL) begin
			efc_q <= pwdata[`FRS_CTRL_EFC];
			pol_q <= pwdata[`FRS_CTRL_POL];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_apbWait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
	a_apbWait: assert property (p_apbWait)
		else $error("access not answered after one wait state");
	property p_slverr; pslverr |-> pready; endproperty
	a_slverr: assert property (p_slverr)
		else $error("error response without ready");
	property p_restartAfterTrip; $rose(faultResetRestart) |-> $past(tripOut); endproperty
	a_restartAfterTrip: assert property (p_restartAfterTrip)
		else $error("restart without a preceding trip");
	property p_restartPulse; faultResetRestart |=> !faultResetRestart; endproperty
	a_restartPulse: assert property (p_restartPulse)
		else $error("restart pulse longer than one cycle");
	property p_minWait; $rose(tripOut) |-> !faultResetRestart [*8]; endproperty
	a_minWait: assert property (p_minWait)
		else $error("restart before the shortest wait");
	property p_excessTrip; retryExcess |-> tripOut && faultOut; endproperty
	a_excessTrip: assert property (p_excessTrip)
		else $error("excess fault without staying tripped");
	property p_gateOffTrip; tripOut && $past(tripOut) |-> !outputGate; endproperty
	a_gateOffTrip: assert property (p_gateOffTrip)
		else $error("output enabled while tripped");
	property p_retryActive; $rose(faultResetRestart) |-> retry_active_out != pol_q; endproperty
	a_retryActive: assert property (p_retryActive)
		else $error("retry active output not asserted at restart");
	property p_earthDelay; $rose(startCmd) && efc_q |-> !outputGate [*8]; endproperty
	a_earthDelay: assert property (p_earthDelay)
		else $error("output not held off for the earth check");
endmodule

bind frs_supervisor frs_supervisor_asserts #(
	.TICK_CYCLES(TICK_CYCLES), .EARTH_CYCLES(EARTH_CYCLES)
) u_chk (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.startCmd(startCmd), .tripOut(tripOut), .faultOut(faultOut),
	.retry_active_out(retry_active_out), .faultResetRestart(faultResetRestart),
	.outputGate(outputGate), .retryExcess(retryExcess)
);

`default_nettype wire

// ---- frs_drive_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module frs_drive_model (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic outputGate,
	input  wire logic brakeReq,
	output var  logic running,
	output var  logic outFreqAbove1Hz,
	output var  logic dcBraking
);
	logic [1:0] ramp_q;

	// Stage follows the gate; frequency passes 1Hz a few cycles later
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			running <= 1'b0;
			ramp_q  <= 2'h0;
		end else begin
			running <= outputGate;
			if (!outputGate) begin
				ramp_q <= 2'h0;
			end else if (ramp_q != 2'h3) begin
				ramp_q <= ramp_q + 2'h1;
			end
		end
	end

	// Braking only matters while the stage runs
	assign outFreqAbove1Hz = (ramp_q == 2'h3);
	assign dcBraking       = running && brakeReq;
endmodule

`default_nettype wire

// ---- test_frs_supervisor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "frs_map.svh"

module test_frs_supervisor;
	import frs_pkg::*;
	localparam int TICK = 20;
	localparam logic [8:0] TAB [13] = '{9'h00D, 9'h041, 9'h046, 9'h087, 9'h084, 9'h0CB,
		9'h0CC, 9'h113, 9'h116, 9'h10E, 9'h145, 9'h142, 9'h027};
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic [19:0] extFault = 0;
	logic startCmd = 0, brakeReq = 0, outPhaseLost = 0, inPhaseLost = 0, regenerating = 0;
	logic earthFaultSense = 0, running, outFreqAbove1Hz, dcBraking, pready, pslverr;
	logic tripOut, faultOut, retry_active_out, faultResetRestart, outputGate, retryExcess;
	frs_fault_t faultRecord;
	int numErrors = 0, testsRun = 0, cycles = 0, succ = 0;

	always #50 clk = ~clk;

	frs_supervisor #(.TICK_CYCLES(TICK), .EARTH_CYCLES(8)) dut (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extFault(extFault), .startCmd(startCmd), .running(running), .dcBraking(dcBraking),
		.outFreqAbove1Hz(outFreqAbove1Hz), .outPhaseLost(outPhaseLost),
		.inPhaseLost(inPhaseLost), .regenerating(regenerating),
		.earthFaultSense(earthFaultSense), .tripOut(tripOut), .faultOut(faultOut),
		.retry_active_out(retry_active_out), .faultResetRestart(faultResetRestart),
		.outputGate(outputGate), .retryExcess(retryExcess), .faultRecord(faultRecord));
	frs_drive_model model (.clk(clk), .resetn(resetn), .outputGate(outputGate),
		.brakeReq(brakeReq), .running(running), .outFreqAbove1Hz(outFreqAbove1Hz),
		.dcBraking(dcBraking));

	// Cut a hung run short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("comparisons %0d, mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		testsRun++;
		if (got !== ex) begin
			numErrors++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask

	task flag(input string nm, input logic ex, input logic got);
		chk(nm, {31'h0, ex}, {31'h0, got});
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer, held until ready is sampled
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (pready !== 1'b1) begin
			numErrors++;
			$display("unexpected pready: expected 1, seen %b", pready);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, ex, q);
	endtask

	task st(input logic [1:0] s);
		apb(1'b0, `FRS_A_STAT, 32'h0);
		chk("state", {30'h0, s}, {30'h0, q[1:0]});
	endtask

	task unlock();
		apb(1'b1, `FRS_A_STAT, 32'h1);
		st(2'd0);
	endtask

	task hit(input logic [4:0] i);
		extFault[i] <= 1'b1;
		@(posedge clk);
		extFault[i] <= 1'b0;
		cyc(2);
	endtask

	task waitRestart();
		int n;
		n = 0;
		while (faultResetRestart !== 1'b1 && n < 80) begin
			@(posedge clk);
			n++;
		end
		flag("restart pulse", 1'b1, faultResetRestart);
	endtask

	task t_regs();
		rd(`FRS_A_CTRL, 32'h70, "control");
		rd(`FRS_A_LIMIT, 32'h0, "limit");
		rd(`FRS_A_WAIT, 32'h00A, "wait");
		rd(`FRS_A_SUCC, 32'h0, "successes");
		apb(1'b0, 8'h14, 32'h0);
		flag("unmapped error", 1'b1, e);
		apb(1'b1, `FRS_A_WAIT, 32'hFFF);
		rd(`FRS_A_WAIT, 32'hE10, "wait clamp");
		apb(1'b1, `FRS_A_WAIT, 32'h0);
		apb(1'b1, `FRS_A_LIMIT, 32'd101);
	endtask

	// Selections 0 to 5 against faults inside their group, and 1 to 5 against a fault outside it
	task t_select();
		for (int k = 0; k < 13; k++) begin
			apb(1'b1, `FRS_A_CTRL, {29'h0, TAB[k][8:6]});
			hit(TAB[k][5:1]);
			if (TAB[k][0]) begin
				flag("fault output", 1'b1, faultOut);
				flag("retry active", 1'b1, retry_active_out);
				waitRestart();
				cyc(6 * TICK);
				st(2'd0);
				succ++;
			end else begin
				chk("record", {27'h0, TAB[k][5:1]}, {27'h0, faultRecord});
				st(2'd3);
				unlock();
			end
		end
		rd(`FRS_A_SUCC, succ, "successes");
		apb(1'b1, `FRS_A_SUCC, 32'h0);
		rd(`FRS_A_SUCC, 32'h0, "cleared successes");
	endtask

	task t_excess();
		apb(1'b1, `FRS_A_LIMIT, 32'h1);
		apb(1'b1, `FRS_A_CTRL, 32'h80);
		hit(5'd0);
		flag("fault output muted", 1'b0, faultOut);
		flag("retry active low", 1'b0, retry_active_out);
		waitRestart();
		cyc(3);
		hit(5'd3);
		cyc(2);
		flag("excess", 1'b1, retryExcess);
		chk("first record", 32'h0, {27'h0, faultRecord});
		unlock();
	endtask

	task t_phase();
		apb(1'b1, `FRS_A_LIMIT, 32'h0);
		apb(1'b1, `FRS_A_CTRL, 32'h10);
		hit(5'd0);
		st(2'd3);
		unlock();
		brakeReq <= 1'b1;
		outPhaseLost <= 1'b1;
		cyc(8);
		flag("trip in braking", 1'b0, tripOut);
		brakeReq <= 1'b0;
		cyc(5);
		flag("output phase trip", 1'b1, tripOut);
		chk("record", 32'd20, {27'h0, faultRecord});
		outPhaseLost <= 1'b0;
		unlock();
		apb(1'b1, `FRS_A_CTRL, 32'h0);
		outPhaseLost <= 1'b1;
		cyc(10);
		flag("disabled phase trip", 1'b0, tripOut);
		outPhaseLost <= 1'b0;
	endtask

	task t_input();
		apb(1'b1, `FRS_A_CTRL, 32'h20);
		regenerating <= 1'b1;
		inPhaseLost <= 1'b1;
		cyc(15 * TICK);
		flag("trip regenerating", 1'b0, tripOut);
		regenerating <= 1'b0;
		cyc(8 * TICK);
		flag("early input trip", 1'b0, tripOut);
		cyc(4 * TICK);
		flag("input phase trip", 1'b1, tripOut);
		chk("record", 32'd19, {27'h0, faultRecord});
		inPhaseLost <= 1'b0;
		unlock();
	endtask

	task t_earth();
		apb(1'b1, `FRS_A_CTRL, 32'h40);
		startCmd <= 1'b0;
		cyc(3);
		startCmd <= 1'b1;
		earthFaultSense <= 1'b1;
		cyc(20);
		flag("earth trip", 1'b1, tripOut);
		chk("record", 32'd9, {27'h0, faultRecord});
		earthFaultSense <= 1'b0;
		unlock();
		startCmd <= 1'b0;
		cyc(3);
		startCmd <= 1'b1;
		cyc(4);
		flag("gate held", 1'b0, outputGate);
		cyc(12);
		flag("gate open", 1'b1, outputGate);
		earthFaultSense <= 1'b1;
		cyc(5);
		flag("late earth trip", 1'b0, tripOut);
		earthFaultSense <= 1'b0;
	endtask

	// Second reset with a storage fault present at power-up
	task t_storage();
		resetn <= 1'b0;
		extFault[14] <= 1'b1;
		cyc(4);
		resetn <= 1'b1;
		cyc(2 * TICK);
		extFault[14] <= 1'b0;
		cyc(2);
		unlock();
		apb(1'b1, `FRS_A_LIMIT, 32'h1);
		hit(5'd0);
		st(2'd3);
	endtask

	initial begin
		cyc(4);
		resetn <= 1'b1;
		startCmd <= 1'b1;
		cyc(20);
		t_regs();
		t_select();
		t_excess();
		t_phase();
		t_input();
		t_earth();
		t_storage();
		print_verdict();
	end
endmodule

`default_nettype wire
